// [can_xcvr_ctrl.sv]
// Purpose: mode selection and protection for a CAN transceiver
// Assumes: all inputs except arst_n_i synchronous to clk_i; analog sensing outside
// Notes:   floating-pin pull-ups modelled by a floating flag per pin
// Contract
// - over-temperature disables driver and blocks transmit path
// - thermal shutdown clears when over-temperature deasserts
// - during thermal shutdown bus stays biased, receive follows bus
// - dominant timeout stops a stuck transmit input holding bus dominant
// - any supply undervoltage disables driver; low logic supply floats bus and receive
// - bus supply low, logic good: standby if mode-select high, else protected
// - after undervoltage clears, wait mode change delay before normal
// - mode-select high: standby, driver off, receive high until wake
// - host drives mode-select; low selects normal with mirrored receive
// - normal: transmit low drives dominant, high leaves recessive
// - normal: receive low for dominant bus, high for recessive
// - floating transmit input is pulled recessive
// - floating mode-select is pulled high, selecting standby
// - falling transmit edge starts timer; 1.2 ms disables driver until recessive
// - standby wake event drives receive output low
module can_xcvr_ctrl (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // host side pins
  input  wire logic txd_i,
  input  wire logic txd_float_i,
  input  wire logic mode_select_i,
  input  wire logic mode_select_float_i,
  output logic      rxd_o,
  output logic      rxd_oe_o,
  // bus side
  input  wire logic bus_dom_i,
  output logic      bus_drive_dom_o,
  output logic      bus_bias_mid_o,
  output logic      bus_bias_gnd_o,
  // protection flags
  input  wire logic thermal_shutdown_i,
  input  wire logic bus_supply_undervoltage_i,
  input  wire logic logic_supply_undervoltage_i,
  // status
  output logic [2:0] state_o
);

  xcvr_ctrl_pkg::dev_state_t st_reg;
  xcvr_ctrl_pkg::dev_state_t st_next;
  logic [xcvr_ctrl_pkg::CNT_W-1:0] dto_cnt_reg;
  logic [xcvr_ctrl_pkg::CNT_W-1:0] mode_cnt_reg;
  logic                            txd_prev_reg;
  logic                            dto_reg;
  logic                            uv_seen_reg;
  logic                            txd_eff;
  logic                            stb_eff;
  logic                            uv_any;
  logic                            woken;
  logic                            rxd_next;
  logic                            rxd_oe_next;
  logic                            drv_next;

  ////////////////////////////////////////////////////////////////////
  // effective pin levels
  assign txd_eff = txd_float_i ? 1'b1 : txd_i;
  assign stb_eff = mode_select_float_i ? 1'b1 : mode_select_i;
  assign uv_any  = bus_supply_undervoltage_i | logic_supply_undervoltage_i;

  ////////////////////////////////////////////////////////////////////
  // dominant timeout: starts on falling edge, clears on recessive
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dto_cnt_reg  <= '0;
      dto_reg      <= 1'b0;
      txd_prev_reg <= 1'b1;
    end else begin
      txd_prev_reg <= txd_eff;
      if (txd_eff || st_reg != xcvr_ctrl_pkg::ST_NORMAL && st_reg != xcvr_ctrl_pkg::ST_DOM_TO) begin
        dto_cnt_reg <= '0;
        dto_reg     <= 1'b0;
      end else if (txd_prev_reg) begin
        dto_cnt_reg <= xcvr_ctrl_pkg::CNT_W'(1);
      end else if (dto_cnt_reg >=
                   xcvr_ctrl_pkg::CNT_W'(xcvr_ctrl_pkg::DOM_TIMEOUT_CYCLES)) begin
        dto_reg <= 1'b1;
      end else begin
        dto_cnt_reg <= dto_cnt_reg + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // mode change delay after undervoltage
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_cnt_reg <= '0;
      uv_seen_reg  <= 1'b1;
    end else if (uv_any) begin
      mode_cnt_reg <= '0;
      uv_seen_reg  <= 1'b1;
    end else if (uv_seen_reg) begin
      if (mode_cnt_reg >= xcvr_ctrl_pkg::CNT_W'(xcvr_ctrl_pkg::MODE_DELAY_CYCLES - 1)) begin
        uv_seen_reg <= 1'b0;
      end else begin
        mode_cnt_reg <= mode_cnt_reg + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state selection by priority
  always_comb begin
    if (logic_supply_undervoltage_i) begin
      st_next = xcvr_ctrl_pkg::ST_PROTECT_HIZ;
    end else if (bus_supply_undervoltage_i) begin
      st_next = stb_eff ? xcvr_ctrl_pkg::ST_STANDBY
                        : xcvr_ctrl_pkg::ST_PROTECT_REC;
    end else if (stb_eff) begin
      st_next = xcvr_ctrl_pkg::ST_STANDBY;
    end else if (uv_seen_reg) begin
      st_next = xcvr_ctrl_pkg::ST_PROTECT_REC;
    end else if (thermal_shutdown_i) begin
      st_next = xcvr_ctrl_pkg::ST_THERMAL;
    end else if (dto_reg) begin
      st_next = xcvr_ctrl_pkg::ST_DOM_TO;
    end else begin
      st_next = xcvr_ctrl_pkg::ST_NORMAL;
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= xcvr_ctrl_pkg::ST_PROTECT_HIZ;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // wake detector active only in standby
  wake_detect u_wake (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .enable_i (st_reg == xcvr_ctrl_pkg::ST_STANDBY),
    .bus_dom_i(bus_dom_i),
    .woken_o  (woken)
  );

  ////////////////////////////////////////////////////////////////////
  // pin output decode
  always_comb begin
    rxd_next    = 1'b1;
    rxd_oe_next = 1'b1;
    drv_next    = 1'b0;
    case (st_next)
      xcvr_ctrl_pkg::ST_PROTECT_HIZ: rxd_oe_next = 1'b0;
      xcvr_ctrl_pkg::ST_PROTECT_REC: rxd_next = 1'b1;
      xcvr_ctrl_pkg::ST_STANDBY:     rxd_next = ~woken;
      xcvr_ctrl_pkg::ST_THERMAL:     rxd_next = ~bus_dom_i;
      xcvr_ctrl_pkg::ST_DOM_TO:      rxd_next = ~bus_dom_i;
      default: begin
        rxd_next = ~bus_dom_i;
        drv_next = ~txd_eff;
      end
    endcase
  end

  // registered pin outputs
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rxd_o           <= 1'b1;
      rxd_oe_o        <= 1'b0;
      bus_drive_dom_o <= 1'b0;
      bus_bias_mid_o  <= 1'b0;
      bus_bias_gnd_o  <= 1'b0;
    end else begin
      rxd_o           <= rxd_next;
      rxd_oe_o        <= rxd_oe_next;
      bus_drive_dom_o <= drv_next;
      bus_bias_mid_o  <= (st_next == xcvr_ctrl_pkg::ST_NORMAL) ||
                         (st_next == xcvr_ctrl_pkg::ST_THERMAL) ||
                         (st_next == xcvr_ctrl_pkg::ST_DOM_TO);
      bus_bias_gnd_o  <= (st_next == xcvr_ctrl_pkg::ST_STANDBY);
    end
  end

  assign state_o = st_reg;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  thermal_driver_off_a: assert property (thermal_shutdown_i && !uv_any && !stb_eff && !uv_seen_reg
    |=> !bus_drive_dom_o && bus_bias_mid_o) else $error("driver on in thermal");
  thermal_rx_follows_a: assert property (st_reg == xcvr_ctrl_pkg::ST_THERMAL
    && $past(st_next) == xcvr_ctrl_pkg::ST_THERMAL |-> rxd_o == !$past(bus_dom_i))
    else $error("rx not following bus");
  thermal_clear_a: assert property (st_reg == xcvr_ctrl_pkg::ST_THERMAL && !thermal_shutdown_i
    && !uv_any && !stb_eff && !dto_reg |=> st_reg == xcvr_ctrl_pkg::ST_NORMAL)
    else $error("thermal not cleared");
  logic_uv_hiz_a: assert property (logic_supply_undervoltage_i
    |=> !rxd_oe_o && !bus_drive_dom_o) else $error("outputs not floated");
  bus_uv_standby_a: assert property (bus_supply_undervoltage_i && !logic_supply_undervoltage_i
    && stb_eff |=> st_reg == xcvr_ctrl_pkg::ST_STANDBY) else $error("no standby");
  bus_uv_protect_a: assert property (bus_supply_undervoltage_i && !logic_supply_undervoltage_i
    && !stb_eff |=> rxd_o && !bus_drive_dom_o) else $error("protect wrong");
  uv_delay_a: assert property ($fell(uv_any)
    |-> !bus_drive_dom_o [*8]) else $error("normal too early");
  standby_rx_high_a: assert property (st_reg == xcvr_ctrl_pkg::ST_STANDBY && !woken
    && $past(!woken) |-> !bus_drive_dom_o && rxd_o) else $error("standby output wrong");
  normal_tx_a: assert property (st_next == xcvr_ctrl_pkg::ST_NORMAL
    |=> bus_drive_dom_o == !$past(txd_eff)) else $error("tx mismatch");
  normal_rx_a: assert property (st_next == xcvr_ctrl_pkg::ST_NORMAL
    |=> rxd_o == !$past(bus_dom_i)) else $error("rx mismatch");
  float_tx_a: assert property (txd_float_i && st_next == xcvr_ctrl_pkg::ST_NORMAL
    |=> !bus_drive_dom_o) else $error("float tx drives");
  float_stb_a: assert property (mode_select_float_i && !logic_supply_undervoltage_i
    |=> st_reg == xcvr_ctrl_pkg::ST_STANDBY) else $error("float stb not standby");
  timeout_limit_a: assert property (dto_cnt_reg <=
    xcvr_ctrl_pkg::CNT_W'(xcvr_ctrl_pkg::DOM_TIMEOUT_CYCLES)) else $error("timer overrun");
  timeout_release_a: assert property (dto_reg && txd_eff |=> !dto_reg)
    else $error("timeout not released");
  wake_rx_low_a: assert property (st_next == xcvr_ctrl_pkg::ST_STANDBY && woken
    |=> !rxd_o) else $error("wake not shown");
  uv_priority_a: assert property (uv_any |=> st_reg != xcvr_ctrl_pkg::ST_NORMAL)
    else $error("priority broken");

  normal_seen_c:  cover property (st_reg == xcvr_ctrl_pkg::ST_NORMAL && bus_drive_dom_o);
  timeout_seen_c: cover property (st_reg == xcvr_ctrl_pkg::ST_DOM_TO);
  wake_seen_c:    cover property (st_reg == xcvr_ctrl_pkg::ST_STANDBY && !rxd_o);
  thermal_seen_c: cover property (st_reg == xcvr_ctrl_pkg::ST_THERMAL);

endmodule : can_xcvr_ctrl

// [can_xcvr_ctrl_bench.sv]
// Purpose: self-checking bench for the transceiver mode and protection block
// Assumes: host model drives transmit and mode pins, bench drives the bus
// Notes:   expected outputs are queued and compared by a monitor process
module can_xcvr_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;

  // stimulus
  logic       clk_i = 1'b0, arst_n_i = 1'b0, tx_req = 1'b1, mode_req = 1'b1;
  logic       txd_float = 1'b0, mode_float = 1'b0, other_dom = 1'b0;
  logic       thermal_shutdown = 1'b0, uv_bus = 1'b0, uv_log = 1'b0;
  // observed
  logic       txd, mode_sel, rxd, rxd_oe, drv, mid, gnd;
  logic [2:0] st;
  wire        bus_dom = drv | other_dom; // any dominant node wins
  int         n_errors = 0, checked = 0, seed = 10825;
  logic [7:0] exp_q[$], care_q[$];
  event       chk_ev;

  host_ctrl_model host_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .tx_req_i(tx_req),
    .mode_req_i(mode_req), .txd_o(txd), .mode_select_o(mode_sel));
  can_xcvr_ctrl dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .txd_i(txd),
    .txd_float_i(txd_float), .mode_select_i(mode_sel), .mode_select_float_i(mode_float),
    .rxd_o(rxd), .rxd_oe_o(rxd_oe), .bus_dom_i(bus_dom), .bus_drive_dom_o(drv),
    .bus_bias_mid_o(mid), .bus_bias_gnd_o(gnd), .thermal_shutdown_i(thermal_shutdown),
    .bus_supply_undervoltage_i(uv_bus), .logic_supply_undervoltage_i(uv_log), .state_o(st));

  ////////////////////////////////////////////////////////////////////////////
  // 10 MHz clock
  always #50 clk_i = ~clk_i;

  // let inputs settle through model and design, then queue a note
  task automatic chk(input logic [4:0] p, input logic [2:0] s, input logic [7:0] c);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    exp_q.push_back({p, s});
    care_q.push_back(c);
    ->chk_ev;
  endtask : chk

  // verdict and end of run
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  // monitor: oldest note against {rxd, oe, drive, mid, gnd, state}
  always @(chk_ev) begin : monitor
    logic [7:0] obs;
    obs = {rxd, rxd_oe, drv, mid, gnd, st};
    checked++;
    if ((obs & care_q[0]) !== (exp_q[0] & care_q[0])) begin
      n_errors++;
      $display("CHECK FAILED at %0t: outputs %b expected %b", $time, obs, exp_q[0]);
    end
    void'(exp_q.pop_front());
    void'(care_q.pop_front());
  end

  // hang guard
  initial begin
    #5000000;
    n_errors++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    test_done();
  end

  // main sequence
  initial begin : main
    logic t, o;
    chk(5'b10000, xcvr_ctrl_pkg::ST_PROTECT_HIZ, 8'hff);
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    chk(5'b11001, xcvr_ctrl_pkg::ST_STANDBY, 8'hff);
    @(posedge clk_i);
    mode_req   <= 1'b0;
    mode_float <= 1'b1;
    chk(5'b11001, xcvr_ctrl_pkg::ST_STANDBY, 8'hff);
    @(posedge clk_i);
    mode_float <= 1'b0;
    repeat (xcvr_ctrl_pkg::MODE_DELAY_CYCLES) @(posedge clk_i);
    chk(5'b11010, xcvr_ctrl_pkg::ST_NORMAL, 8'hff);
    $display("test reset and mode select done");
    // random traffic with another node on the bus
    repeat (40) begin
      t = 1'($random(seed));
      o = 1'($random(seed));
      @(posedge clk_i);
      tx_req    <= t;
      other_dom <= o;
      chk({t & ~o, 1'b1, ~t, 2'b10}, xcvr_ctrl_pkg::ST_NORMAL, 8'hff);
    end
    $display("test normal traffic done");
    @(posedge clk_i);
    tx_req    <= 1'b0;
    other_dom <= 1'b0;
    txd_float <= 1'b1;
    chk(5'b11010, xcvr_ctrl_pkg::ST_NORMAL, 8'hff);
    @(posedge clk_i);
    txd_float <= 1'b0;
    tx_req    <= 1'b1;
    chk(5'b11010, xcvr_ctrl_pkg::ST_NORMAL, 8'hff);
    @(posedge clk_i);
    tx_req <= 1'b0;
    repeat (xcvr_ctrl_pkg::DOM_TIMEOUT_CYCLES - 100) @(posedge clk_i);
    chk(5'b01110, xcvr_ctrl_pkg::ST_NORMAL, 8'hff);
    repeat (200) @(posedge clk_i);
    other_dom <= 1'b1;
    chk(5'b01010, xcvr_ctrl_pkg::ST_DOM_TO, 8'hff);
    @(posedge clk_i);
    tx_req    <= 1'b1;
    other_dom <= 1'b0;
    chk(5'b11010, xcvr_ctrl_pkg::ST_NORMAL, 8'hff);
    $display("test dominant timeout done");
    @(posedge clk_i);
    tx_req    <= 1'b0;
    thermal_shutdown       <= 1'b1;
    other_dom <= 1'b1;
    chk(5'b01010, xcvr_ctrl_pkg::ST_THERMAL, 8'hff);
    @(posedge clk_i);
    thermal_shutdown <= 1'b0;
    chk(5'b01110, xcvr_ctrl_pkg::ST_NORMAL, 8'hff);
    @(posedge clk_i);
    tx_req    <= 1'b1;
    other_dom <= 1'b0;
    thermal_shutdown       <= 1'b1;
    uv_bus    <= 1'b1;
    chk(5'b11000, xcvr_ctrl_pkg::ST_PROTECT_REC, 8'hff);
    @(posedge clk_i);
    mode_req <= 1'b1;
    chk(5'b11001, xcvr_ctrl_pkg::ST_STANDBY, 8'hff);
    @(posedge clk_i);
    uv_log <= 1'b1;
    chk(5'b00000, xcvr_ctrl_pkg::ST_PROTECT_HIZ, 8'h7f);
    @(posedge clk_i);
    {thermal_shutdown, uv_bus, uv_log, mode_req, tx_req} <= 5'h00;
    repeat (xcvr_ctrl_pkg::MODE_DELAY_CYCLES - 50) @(posedge clk_i);
    chk(5'b11000, xcvr_ctrl_pkg::ST_PROTECT_REC, 8'hff);
    repeat (60) @(posedge clk_i);
    chk(5'b01110, xcvr_ctrl_pkg::ST_NORMAL, 8'hff);
    $display("test thermal and undervoltage done");
    @(posedge clk_i);
    tx_req   <= 1'b1;
    mode_req <= 1'b1;
    chk(5'b11001, xcvr_ctrl_pkg::ST_STANDBY, 8'hff);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      other_dom <= ~i[0];
      if (i == 1) chk(5'b11001, xcvr_ctrl_pkg::ST_STANDBY, 8'hff);
      repeat (xcvr_ctrl_pkg::WAKE_FILTER_CYCLES + 3) @(posedge clk_i);
    end
    chk(5'b01001, xcvr_ctrl_pkg::ST_STANDBY, 8'hff);
    @(posedge clk_i);
    mode_req <= 1'b0;
    chk(5'b11010, xcvr_ctrl_pkg::ST_NORMAL, 8'hff);
    $display("test wake pattern done");
    @(posedge clk_i);
    test_done();
  end
endmodule : can_xcvr_ctrl_bench

// [host_ctrl_model.sv]
// Purpose: host protocol controller model driving the transceiver pins
// Assumes: bench requests change just after the rising clock edge
// Notes:   pins follow requests one clock later; recessive and standby at reset
module host_ctrl_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // requests from the bench
  input  wire logic tx_req_i,
  input  wire logic mode_req_i,
  // transceiver pins
  output logic      txd_o,
  output logic      mode_select_o
);
  timeunit 1ns;
  timeprecision 1ns;

  ////////////////////////////////////////////////////////////////////////////
  // controller pins, mode always driven rather than left to the pull-up
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      txd_o         <= 1'b1;
      mode_select_o <= 1'b1;
    end else begin
      txd_o         <= tx_req_i;
      mode_select_o <= mode_req_i;
    end
  end
endmodule : host_ctrl_model

// [wake_detect.sv]
// Purpose: wake pattern detector used in standby
// Assumes: bus_dom_i synchronous to clk_i
// Notes:   dominant, recessive, dominant, recessive, each filtered
module wake_detect (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // control
  input  wire logic enable_i,
  input  wire logic bus_dom_i,
  // result
  output logic      woken_o
);

  xcvr_ctrl_pkg::wake_state_t wk_reg;
  logic [xcvr_ctrl_pkg::CNT_W-1:0] flt_reg;
  logic                            last_reg;
  logic                            filt;

  // current bus level held long enough; a fresh change never counts as filtered
  assign filt = (flt_reg >= xcvr_ctrl_pkg::CNT_W'(xcvr_ctrl_pkg::WAKE_FILTER_CYCLES)) &&
                (bus_dom_i == last_reg);

  // filter counter restarts on every bus change
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flt_reg  <= '0;
      last_reg <= 1'b0;
    end else begin
      last_reg <= bus_dom_i;
      if (!enable_i || bus_dom_i != last_reg) begin
        flt_reg <= '0;
      end else if (!filt) begin
        flt_reg <= flt_reg + 1'b1;
      end
    end
  end

  // pattern sequencer
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wk_reg <= xcvr_ctrl_pkg::WK_IDLE;
    end else if (!enable_i) begin
      wk_reg <= xcvr_ctrl_pkg::WK_IDLE;
    end else begin
      case (wk_reg)
        xcvr_ctrl_pkg::WK_IDLE: if (filt && bus_dom_i) wk_reg <= xcvr_ctrl_pkg::WK_DOM1;
        xcvr_ctrl_pkg::WK_DOM1: if (filt && !bus_dom_i) wk_reg <= xcvr_ctrl_pkg::WK_REC1;
        xcvr_ctrl_pkg::WK_REC1: if (filt && bus_dom_i) wk_reg <= xcvr_ctrl_pkg::WK_DOM2;
        xcvr_ctrl_pkg::WK_DOM2: if (filt && !bus_dom_i) wk_reg <= xcvr_ctrl_pkg::WK_WOKEN;
        default: wk_reg <= wk_reg;
      endcase
    end
  end

  assign woken_o = (wk_reg == xcvr_ctrl_pkg::WK_WOKEN);

endmodule : wake_detect

// [xcvr_ctrl_pkg.sv]
// Purpose: shared constants for the transceiver mode and protection block
// Assumes: 10 MHz clock, period 100 ns
// Notes:   timing counts derive from the printed times
package xcvr_ctrl_pkg;

  // clock rate
  localparam int unsigned CLK_PERIOD_NS = 100;

  // dominant timeout, longest time, rounded down
  localparam int unsigned DOM_TIMEOUT_US     = 1200;
  localparam int unsigned DOM_TIMEOUT_CYCLES = (DOM_TIMEOUT_US * 1000) / CLK_PERIOD_NS;

  // mode change delay after undervoltage clears (least time, rounded up)
  localparam int unsigned MODE_DELAY_NS     = 20000;
  localparam int unsigned MODE_DELAY_CYCLES =
    (MODE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // wake filter time (least time, rounded up)
  localparam int unsigned WAKE_FILTER_NS     = 1000;
  localparam int unsigned WAKE_FILTER_CYCLES =
    (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // counter width
  localparam int unsigned CNT_W = 16;

  // device states
  typedef enum logic [2:0] {
    ST_PROTECT_HIZ = 3'b000,
    ST_PROTECT_REC = 3'b001,
    ST_STANDBY     = 3'b010,
    ST_NORMAL      = 3'b011,
    ST_THERMAL     = 3'b100,
    ST_DOM_TO      = 3'b101
  } dev_state_t;

  // wake pattern detector phases
  typedef enum logic [2:0] {
    WK_IDLE  = 3'b000,
    WK_DOM1  = 3'b001,
    WK_REC1  = 3'b010,
    WK_DOM2  = 3'b011,
    WK_WOKEN = 3'b100
  } wake_state_t;

endpackage : xcvr_ctrl_pkg
